// File: rtl/ctm_compact_timer.sv
// Compact 10-bit timer with compare match, PWM and timer modes behind an APB slave.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`include "ctm_map.svh"
module ctm_compact_timer
   import ctm_pkg::*;
(
   // Clock and reset.
   input  wire logic        REF_CLK,
   input  wire logic        RESET_N,
   // APB slave.
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic             PREADY,
   output logic [31:0]      PRDATA,
   output logic             PSLVERR,
   // Selected timer clock tick, one cycle wide.
   input  wire logic        TICK,
   // Timer output pin.
   output logic             TIMER_OUT,
   output logic             TIMER_OUT_EN_N
);

   ctm_ctrl0_t  ctrl0;
   ctm_ctrl1_t  ctrl1;
   logic [9:0]  compare_a_value;
   logic [9:0]  count;
   logic        match_a_flag;
   logic        match_p_flag;
   logic        enable_q;
   logic        pin_level;
   logic        pwm_active;
   logic        setup_ok;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic [31:0] next_rdata;
   logic        enable_rise;
   logic        tick_run;
   logic        match_a;
   logic        match_p;
   logic        at_max;
   logic        pwm_mode;
   logic        cmp_mode;
   logic        clear_cnt;
   logic        set_af;
   logic        set_pf;
   logic [10:0] duty_val;
   logic [10:0] period_val;
   logic        next_pin;
   logic        next_active;

   // The first access cycle is the one wait state; the access takes effect at its end.
   assign setup_ok = PSEL & PENABLE & ~PREADY;
   assign wr_en    = setup_ok & PWRITE & addr_ok;
   assign rd_en    = setup_ok & ~PWRITE;

   // Read mux; unmapped addresses answer with an error and zero data.
   always_comb begin
      next_rdata = 32'h0000_0000;
      addr_ok    = 1'b1;
      unique case (PADDR)
         `CTM_OFF_CTRL0:   next_rdata[3:0] = ctrl0;
         `CTM_OFF_CTRL1:   next_rdata[7:0] = ctrl1;
         `CTM_OFF_CNT_LO:  next_rdata[7:0] = count[7:0];
         `CTM_OFF_CNT_HI:  next_rdata[1:0] = count[9:8];
         `CTM_OFF_CMPA_LO: next_rdata[7:0] = compare_a_value[7:0];
         `CTM_OFF_CMPA_HI: next_rdata[1:0] = compare_a_value[9:8];
         `CTM_OFF_STATUS: begin
            next_rdata[`CTM_ST_AF] = match_a_flag;
            next_rdata[`CTM_ST_PF] = match_p_flag;
         end
         default:          addr_ok = 1'b0;
      endcase
   end

   // Bus answer registers.
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= setup_ok;
         PSLVERR <= setup_ok & ~addr_ok;
         if (rd_en) begin
            PRDATA <= next_rdata;
         end
      end
   end

   // Control and compare registers; software should stop the timer before mode changes.
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl0           <= ctm_ctrl0_t'(`CTM_RST_BYTE);
         ctrl1           <= ctm_ctrl1_t'(`CTM_RST_BYTE);
         compare_a_value <= `CTM_RST_CMPA;
      end else if (wr_en) begin
         unique case (PADDR)
            `CTM_OFF_CTRL0:   ctrl0 <= PWDATA[3:0];
            `CTM_OFF_CTRL1:   ctrl1 <= PWDATA[7:0];
            `CTM_OFF_CMPA_LO: compare_a_value[7:0] <= PWDATA[7:0];
            `CTM_OFF_CMPA_HI: compare_a_value[9:8] <= PWDATA[1:0];
            default:          ;
         endcase
      end
   end

   // Comparator and mode decode.
   assign enable_rise = ctrl0.timer_enable & ~enable_q;
   assign tick_run    = ctrl0.timer_enable & enable_q & TICK;
   assign match_a     = (count == compare_a_value);
   // Period hit on the tick that would carry the count into the coded multiple of 128.
   assign match_p     = (count[`CTM_PERIOD_LSB-1:0] == 7'h7f)
                        && (3'(count[9:`CTM_PERIOD_LSB] + 3'h1)
                            == ctrl0.period_compare_value);
   assign at_max      = (count == `CTM_CNT_MAX);
   assign pwm_mode    = (ctrl1.mode == CTM_MODE_PWM);
   assign cmp_mode    = (ctrl1.mode == CTM_MODE_CMP);

   // Clear and flag events, evaluated on the tick that leaves the matching count.
   always_comb begin
      clear_cnt = 1'b0;
      set_af    = 1'b0;
      set_pf    = 1'b0;
      if (tick_run) begin
         if (pwm_mode) begin
            set_af = match_a;
            set_pf = match_p;
            if (ctrl1.period_duty_swap) begin
               clear_cnt = match_a | at_max;
            end else begin
               clear_cnt = match_p | at_max;
            end
         end else if (ctrl1.clear_select) begin
            set_af    = match_a & (compare_a_value != `CTM_RST_CMPA);
            clear_cnt = set_af | at_max;
         end else begin
            set_af    = match_a;
            set_pf    = match_p;
            clear_cnt = match_p | at_max;
         end
      end
   end

   // Counter: zeroed on enable rise, held while off, counts on ticks.
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         count    <= `CTM_RST_CNT;
         enable_q <= 1'b0;
      end else begin
         enable_q <= ctrl0.timer_enable;
         if (enable_rise) begin
            count <= `CTM_RST_CNT;
         end else if (clear_cnt) begin
            count <= `CTM_RST_CNT;
         end else if (tick_run) begin
            count <= count + 10'h001;
         end
      end
   end

   // Match flags: hardware set wins over a software write-one-to-clear.
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         match_a_flag <= 1'b0;
         match_p_flag <= 1'b0;
      end else begin
         if (set_af) begin
            match_a_flag <= 1'b1;
         end else if (wr_en && PADDR == `CTM_OFF_STATUS && PWDATA[`CTM_ST_AF]) begin
            match_a_flag <= 1'b0;
         end
         if (set_pf) begin
            match_p_flag <= 1'b1;
         end else if (wr_en && PADDR == `CTM_OFF_STATUS && PWDATA[`CTM_ST_PF]) begin
            match_p_flag <= 1'b0;
         end
      end
   end

   // PWM duty and period as counts; code zero stands for 1024 clocks.
   always_comb begin
      if (ctrl1.period_duty_swap) begin
         period_val = {1'b0, compare_a_value} + 11'h001;
         duty_val   = (ctrl0.period_compare_value == 3'h0) ? 11'h400
                      : {1'b0, ctrl0.period_compare_value, 7'h00};
      end else begin
         period_val = (ctrl0.period_compare_value == 3'h0) ? 11'h400
                      : {1'b0, ctrl0.period_compare_value, 7'h00};
         duty_val   = {1'b0, compare_a_value};
      end
   end

   // Waveform active while the count is below the duty, or always at full duty.
   assign next_active = (duty_val >= period_val) | ({1'b0, count} < duty_val);

   // Pin level per mode.
   always_comb begin
      next_pin = pin_level;
      if (enable_rise) begin
         next_pin = ctrl1.output_control;
      end else if (cmp_mode && set_af) begin
         unique case (ctrl1.pin_function)
            2'h0: next_pin = pin_level;
            2'h1: next_pin = 1'b0;
            2'h2: next_pin = 1'b1;
            2'h3: next_pin = ~pin_level;
         endcase
      end else if (pwm_mode) begin
         unique case (ctrl1.pin_function)
            2'h0: next_pin = ~ctrl1.output_control;
            2'h1: next_pin = ctrl1.output_control;
            2'h2: next_pin = pwm_active ~^ ctrl1.output_control;
            2'h3: next_pin = pin_level;
         endcase
      end
   end

   // Pin state, polarity and enable registers; timer mode releases the pin.
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_level      <= 1'b0;
         pwm_active     <= 1'b0;
         TIMER_OUT      <= 1'b0;
         TIMER_OUT_EN_N <= 1'b1;
      end else begin
         pwm_active     <= next_active & ctrl0.timer_enable;
         pin_level      <= next_pin;
         TIMER_OUT      <= next_pin ^ ctrl1.output_polarity;
         TIMER_OUT_EN_N <= ~(cmp_mode | pwm_mode);
      end
   end

endmodule

// File: rtl/ctm_map.svh
// Register offsets, field positions, reset values and counts of the compact timer.
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH
`define CTM_OFF_CTRL0     12'h000
`define CTM_OFF_CTRL1     12'h004
`define CTM_OFF_CNT_LO    12'h008
`define CTM_OFF_CNT_HI    12'h00c
`define CTM_OFF_CMPA_LO   12'h010
`define CTM_OFF_CMPA_HI   12'h014
`define CTM_OFF_STATUS    12'h018
`define CTM_C0_ON         3
`define CTM_C0_RP_HI      2
`define CTM_C0_RP_LO      0
`define CTM_C1_MODE_HI    7
`define CTM_C1_MODE_LO    6
`define CTM_C1_IO_HI      5
`define CTM_C1_IO_LO      4
`define CTM_C1_OC         3
`define CTM_C1_POL        2
`define CTM_C1_DPX        1
`define CTM_C1_CCLR       0
`define CTM_ST_AF         0
`define CTM_ST_PF         1
`define CTM_RST_BYTE      8'h00
`define CTM_RST_CNT       10'h000
`define CTM_RST_CMPA      10'h000
`define CTM_CNT_MAX       10'h3ff
`define CTM_PERIOD_LSB    7
`define CTM_ADDR_HI       11
`define CTM_ADDR_LO       2
`endif

// File: rtl/ctm_pkg.sv
// Types shared by the compact timer design.
package ctm_pkg;
   typedef enum logic [1:0] {
      CTM_MODE_CMP = 2'h0,
      CTM_MODE_UND = 2'h1,
      CTM_MODE_PWM = 2'h2,
      CTM_MODE_TMR = 2'h3
   } ctm_mode_t;

   typedef struct packed {
      ctm_mode_t  mode;
      logic [1:0] pin_function;
      logic       output_control;
      logic       output_polarity;
      logic       period_duty_swap;
      logic       clear_select;
   } ctm_ctrl1_t;

   typedef struct packed {
      logic       timer_enable;
      logic [2:0] period_compare_value;
   } ctm_ctrl0_t;
endpackage

// File: verif/ctm_compact_timer_checker.sv
// Concurrent checks on the ports of the compact timer.
module ctm_compact_timer_checker
   import ctm_pkg::*;
(
   // Clock, reset and APB.
   input wire logic        REF_CLK,
   input wire logic        RESET_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic [31:0] PRDATA,
   input wire logic        PSLVERR,
   // Tick and pin.
   input wire logic        TICK,
   input wire logic        TIMER_OUT,
   input wire logic        TIMER_OUT_EN_N
);
   logic [7:0] c1;
   logic [3:0] c0;
   // Shadows of both control bytes, taken at the edge where a write lands.
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         c1 <= 8'h00;
         c0 <= 4'h0;
      end else if (PSEL && PENABLE && !PREADY && PWRITE) begin
         if (PADDR == 12'h004) c1 <= PWDATA[7:0];
         if (PADDR == 12'h000) c0 <= PWDATA[3:0];
      end
   end
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESET_N);
   pready_wait_a: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
      else $error("ready not after one wait cycle");
   pready_one_a: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   slverr_map_a: assert property (PREADY |-> PSLVERR == (PADDR > 12'h018))
      else $error("error response wrong for address");
   hi_zero_a: assert property (PREADY && !PWRITE && (PADDR == 12'h00c || PADDR == 12'h014)
      |-> PRDATA[31:2] == 30'h0) else $error("high byte upper bits not zero");
   tmr_pin_off_a: assert property (c1[7:6] == 2'h3 ##1 c1[7:6] == 2'h3 |=> TIMER_OUT_EN_N)
      else $error("pin driven in timer mode");
   en_init_a: assert property ($rose(c0[3]) && c1[7:6] == 2'h0
      |-> ##[1:2] TIMER_OUT == (c1[3] ^ c1[2])) else $error("pin not at initial level");
   cmp_hold_a: assert property (c1[7:4] == 4'h0 && $stable(c1) && $stable(c0) ##1
      $stable(c1) && $stable(c0) |=> $stable(TIMER_OUT)) else $error("pin moved with no action");
   pwm_force_a: assert property (c1[7:5] == 3'b100 && c0[3] && $stable(c1) && $stable(c0) ##1
      $stable(c1) && $stable(c0) |-> TIMER_OUT == ~(c1[4] ^ c1[3] ^ c1[2]))
      else $error("forced pin level wrong");
endmodule

// File: verif/ctm_load_model.sv
// Load on the timer pin: resolves the pulled-down wire and counts its high cycles.
module ctm_load_model (
   // Clock and measurement control.
   input  wire logic clk,
   input  wire logic clr,
   input  wire logic win,
   // Pin as driven by the timer, and the resolved wire.
   input  wire logic drive,
   input  wire logic drive_en_n,
   output logic      level,
   output int        high_cycles
);
   timeunit 1ns;
   timeprecision 1ns;
   // A released pin falls to the pull-down level.
   assign level = drive_en_n ? 1'b0 : drive;
   // Counts high cycles while the window is open.
   always_ff @(posedge clk) begin
      if (clr) high_cycles <= 0;
      else if (win) high_cycles <= high_cycles + int'(level);
   end
endmodule

// File: verif/test_compact_timer_modes.sv
// Self-checking bench for the compact timer through its APB port and pin.
module test_compact_timer_modes;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_n, psel, penable, pwrite, tick, pin, pin_en_n;
   logic        pready, pslverr, clr, win, err, level;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   int          miscompares, comparisons, high_cycles;
   logic [1:0]  fn[4] = '{2'h2, 2'h1, 2'h3, 2'h0};
   logic        oc[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   logic        ex[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   // Design and the load on its pin.
   ctm_compact_timer i_dut (.REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
      .PSLVERR(pslverr), .TICK(tick), .TIMER_OUT(pin), .TIMER_OUT_EN_N(pin_en_n));
   ctm_load_model i_load (.clk(clk), .clr(clr), .win(win), .drive(pin),
      .drive_en_n(pin_en_n), .level(level), .high_cycles(high_cycles));
   // Clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Counts a comparison and reports a mismatch.
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer, holding the request until ready is sampled.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) miscompares++;
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), rdv, exp);
   endtask
   // Holds the tick high for n cycles.
   task automatic tk(input int n);
      tick <= 1'b1;
      repeat (n) @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
   endtask
   // Runs one PWM setting and measures high cycles over 256 clocks.
   task automatic pwm(input logic [7:0] c1, input logic [7:0] a, input int hi,
                      input logic [31:0] fl);
      wr(12'h000, 8'h01);
      wr(12'h018, 8'h03);
      wr(12'h004, c1);
      wr(12'h010, a);
      wr(12'h000, 8'h09);
      tick <= 1'b1;
      repeat (16) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      win <= 1'b1;
      repeat (256) @(posedge clk);
      win <= 1'b0;
      tick <= 1'b0;
      @(posedge clk);
      chk("pwm high", high_cycles, hi);
      rd(12'h018, fl);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      conclude();
   end
   // Test sequence.
   initial begin
      {rst_n, psel, penable, pwrite, tick, clr, win} = 7'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      miscompares = 0;
      comparisons = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(12'h00c, 32'h0);
      rd(12'h014, 32'h0);
      wr(12'h010, 8'ha5);
      wr(12'h014, 8'hff);
      wr(12'h00c, 8'h03);
      rd(12'h010, 32'ha5);
      rd(12'h014, 32'h3);
      rd(12'h00c, 32'h0);
      rd(12'h040, 32'h0);
      chk("unmapped error", err, 1'b1);
      wr(12'h014, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(12'h000, 8'h00);
         wr(12'h018, 8'h03);
         wr(12'h004, {2'b00, fn[i], oc[i], 3'b001});
         wr(12'h010, 8'h05);
         wr(12'h000, 8'h08);
         repeat (3) @(posedge clk);
         chk("initial pin", level, oc[i]);
         tk(6);
         repeat (2) @(posedge clk);
         chk("pin after match", level, ex[i]);
         rd(12'h018, 32'h1);
         rd(12'h008, 32'h0);
      end
      wr(12'h000, 8'h00);
      wr(12'h018, 8'h03);
      wr(12'h004, 8'h00);
      wr(12'h010, 8'h40);
      wr(12'h000, 8'h09);
      tk(128);
      rd(12'h018, 32'h3);
      rd(12'h008, 32'h0);
      wr(12'h000, 8'h00);
      wr(12'h004, 8'hc1);
      wr(12'h010, 8'h00);
      wr(12'h018, 8'h03);
      wr(12'h000, 8'h08);
      tk(1023);
      rd(12'h008, 32'hff);
      rd(12'h00c, 32'h3);
      chk("pin released", pin_en_n, 1'b1);
      wr(12'h000, 8'h00);
      tk(4);
      rd(12'h008, 32'hff);
      wr(12'h000, 8'h08);
      rd(12'h008, 32'h0);
      tk(1024);
      rd(12'h008, 32'h0);
      rd(12'h018, 32'h0);
      pwm(8'ha8, 8'h20, 64, 32'h3);
      pwm(8'ha0, 8'h20, 192, 32'h3);
      pwm(8'hac, 8'h20, 192, 32'h3);
      pwm(8'ha9, 8'hc8, 256, 32'h2);
      pwm(8'haa, 8'hff, 128, 32'h3);
      pwm(8'h98, 8'h20, 256, 32'h3);
      pwm(8'h88, 8'h20, 0, 32'h3);
      conclude();
   end
endmodule
bind ctm_compact_timer ctm_compact_timer_checker i_chk (.REF_CLK, .RESET_N, .PSEL, .PENABLE,
   .PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA, .PSLVERR, .TICK, .TIMER_OUT, .TIMER_OUT_EN_N);
